//--- mqfc_pkg.sv
// Purpose: Shared constants and types for the multi-queue flow-control FIFO
// Assumes: Single clock, one shared write port and one shared read port
// Notes: Port width codes, packet marker bits and default flag offsets
package mqfc_pkg;
  localparam int DATA_W = 36;
  localparam int QUEUES = 16;
  localparam int QADDR_W = 4;
  localparam int SECTOR_W = 8;
  localparam int SECTOR_BIT = 3;
  localparam int BLOCK_WORDS = 256;
  localparam int POOL_BLOCKS_DEF = 64;
  localparam int BLOCKS_W = 9;
  localparam int NQ_W = 5;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int FIFO_MARGIN = 2;
  localparam int SOP_BIT = 34;
  localparam int EOP_BIT = 35;
  localparam int OFFSET_LOW = 8;
  localparam int OFFSET_HIGH = 128;
  localparam logic [1:0] WIDTH_X36 = 2'h0;
  localparam logic [1:0] WIDTH_X18 = 2'h1;
  localparam logic [1:0] WIDTH_X9 = 2'h2;
  localparam logic [1:0] LAST_X36 = 2'h0;
  localparam logic [1:0] LAST_X18 = 2'h1;
  localparam logic [1:0] LAST_X9 = 2'h3;
  localparam logic [1:0] INIT_WAIT = 2'h3;
  typedef enum logic {SECTOR_ONE, SECTOR_TWO} mqfc_sector_t;
endpackage

//--- mqfc_stream_if.sv
// Purpose: Valid/ready word stream between the core and its ingress FIFO
// Assumes: Word taken when valid and ready are both high on a clock edge
// Notes: Data holds the target queue above the 36-bit word
`timescale 1ns/1ps
interface mqfc_stream_if #(parameter int W = 40) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

//--- mqfc_fifo.sv
// Purpose: Small ingress FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Pointers wrap by overflow; level is exported for early back-pressure
`timescale 1ns/1ps
module mqfc_fifo #(
  parameter int W = 40,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  mqfc_stream_if.sink push,
  mqfc_stream_if.source pop,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  assign push.ready = (cnt_reg != CW'(DEPTH));
  assign pop.valid = (cnt_reg != '0);
  assign pop.data = mem[rptr_reg];
  assign do_push = push.valid && push.ready;
  assign do_pop = pop.valid && pop.ready;
  assign level_o = cnt_reg;

  always_comb begin
    wptr_next = do_push ? PW'(wptr_reg + 1'b1) : wptr_reg;
    rptr_next = do_pop ? PW'(rptr_reg + 1'b1) : rptr_reg;
    cnt_next = CW'(cnt_reg + CW'(do_push) - CW'(do_pop));
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; empty count guards it
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wptr_reg] <= push.data;
    end
  end

  a_fifo_bounded: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cnt_reg <= CW'(DEPTH)) else $error("Ingress FIFO count above depth");
  a_fifo_count_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (do_push && !do_pop) |=> cnt_reg == CW'($past(cnt_reg) + 1'b1))
    else $error("Ingress FIFO count did not grow on push");
endmodule

//--- mqfc_core.sv
// Purpose: Multi-queue flow-control FIFO, up to sixteen queues in one block pool
// Assumes: Write and read ports share clk_i; config inputs static after reset
// Notes: Ingress FIFO buffers packed words ahead of the pool
`timescale 1ns/1ps
module mqfc_core #(
  parameter int POOL_BLOCKS = mqfc_pkg::POOL_BLOCKS_DEF,
  parameter int FIFO_DEPTH = mqfc_pkg::FIFO_DEPTH_DEF,
  parameter int CW = $clog2(POOL_BLOCKS * mqfc_pkg::BLOCK_WORDS) + 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [mqfc_pkg::NQ_W-1:0] num_queues_i,
  input wire logic [mqfc_pkg::BLOCKS_W-1:0] blocks_per_queue_i,
  input wire logic [1:0] in_width_i,
  input wire logic [1:0] out_width_i,
  input wire logic packet_mode_i,
  input wire logic polled_mode_i,
  input wire logic default_offset_select_i,
  input wire logic offset_load_i,
  input wire logic [mqfc_pkg::QADDR_W-1:0] offset_queue_i,
  input wire logic [CW-1:0] offset_almost_full_i,
  input wire logic [CW-1:0] offset_almost_empty_i,
  input wire logic write_enable_i,
  input wire logic [mqfc_pkg::QADDR_W-1:0] write_queue_address_i,
  input wire logic [mqfc_pkg::DATA_W-1:0] din_i,
  input wire logic read_enable_i,
  input wire logic [mqfc_pkg::QADDR_W-1:0] read_queue_address_i,
  input wire logic full_bus_sector_strobe_i,
  input wire logic empty_bus_sector_strobe_i,
  output logic [mqfc_pkg::DATA_W-1:0] dout_o,
  output logic queue_full_flag_o,
  output logic almost_full_flag_o,
  output logic output_valid_flag_o,
  output logic almost_empty_flag_o,
  output logic packet_ready_flag_o,
  output logic [mqfc_pkg::SECTOR_W-1:0] almost_full_status_bus_o,
  output logic [mqfc_pkg::SECTOR_W-1:0] almost_empty_status_bus_o,
  output logic full_bus_sector_o,
  output logic empty_bus_sector_o
);
  localparam int AW = CW - 1;
  localparam int DW = mqfc_pkg::DATA_W;
  localparam int QN = mqfc_pkg::QUEUES;
  localparam int QA = mqfc_pkg::QADDR_W;
  localparam int EW = DW + QA;
  localparam int SW = mqfc_pkg::SECTOR_W;

  // Pool memory; one array, queues are contiguous block runs
  logic [DW-1:0] pool_mem [POOL_BLOCKS * mqfc_pkg::BLOCK_WORDS];

  logic [CW-1:0] cnt_reg [QN];
  logic [CW-1:0] cnt_next [QN];
  logic [CW-1:0] wptr_reg [QN];
  logic [CW-1:0] wptr_next [QN];
  logic [CW-1:0] rptr_reg [QN];
  logic [CW-1:0] rptr_next [QN];
  logic [CW-1:0] pkt_reg [QN];
  logic [CW-1:0] pkt_next [QN];
  logic [QN-1:0] inpkt_reg, inpkt_next;
  logic [CW-1:0] af_off_reg [QN];
  logic [CW-1:0] af_off_next [QN];
  logic [CW-1:0] ae_off_reg [QN];
  logic [CW-1:0] ae_off_next [QN];

  logic [QN-1:0] q_ok, af_vec, ae_vec, pr_vec;
  logic [mqfc_pkg::NQ_W-1:0] nq;
  logic [CW-1:0] depth;
  logic wide_both, pkt_en;
  logic [1:0] iw, ow, in_last, out_last;

  // Strap synchroniser and init window for default offsets
  logic strap_meta_reg, strap_sync_reg;
  logic [1:0] init_cnt_reg, init_cnt_next;

  logic [DW-1:0] pack_reg, pack_next;
  logic [1:0] ipart_reg, ipart_next, opart_reg, opart_next;
  logic [DW-1:0] dout_reg, dout_next;
  logic ov_reg, ov_next;
  logic full_reg, full_next, af_reg, af_next, ae_reg, ae_next, pr_reg, pr_next;
  mqfc_pkg::mqfc_sector_t af_sec_reg, af_sec_next, ae_sec_reg, ae_sec_next;
  logic [SW-1:0] af_bus_reg, af_bus_next, ae_bus_reg, ae_bus_next;

  logic accept, word_done, drain, load, consume;
  logic [QA-1:0] dq, rq, wq;
  logic [DW-1:0] dword, rword, placed;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  mqfc_stream_if #(.W(EW)) push_s ();
  mqfc_stream_if #(.W(EW)) pop_s ();

  mqfc_fifo #(.W(EW), .DEPTH(FIFO_DEPTH)) u_ingress (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .push(push_s.sink),
    .pop(pop_s.source),
    .level_o(fifo_level)
  );

  function automatic logic [AW-1:0] base_of(input logic [QA-1:0] q,
                                            input logic [mqfc_pkg::BLOCKS_W-1:0] b);
    base_of = AW'(32'(q) * 32'(b) * 32'(mqfc_pkg::BLOCK_WORDS));
  endfunction

  function automatic logic [1:0] last_of(input logic [1:0] w);
    case (w)
      mqfc_pkg::WIDTH_X18: last_of = mqfc_pkg::LAST_X18;
      mqfc_pkg::WIDTH_X9: last_of = mqfc_pkg::LAST_X9;
      default: last_of = mqfc_pkg::LAST_X36;
    endcase
  endfunction

  always_comb begin
    // Clamp queue count to one..sixteen
    if (num_queues_i == '0) begin
      nq = mqfc_pkg::NQ_W'(1);
    end else if (num_queues_i > mqfc_pkg::NQ_W'(QN)) begin
      nq = mqfc_pkg::NQ_W'(QN);
    end else begin
      nq = num_queues_i;
    end
    // Illegal narrow/narrow pair falls back to x36 in
    iw = (in_width_i != mqfc_pkg::WIDTH_X36 && out_width_i != mqfc_pkg::WIDTH_X36) ?
         mqfc_pkg::WIDTH_X36 : in_width_i;
    ow = out_width_i;
    wide_both = (iw == mqfc_pkg::WIDTH_X36) && (ow == mqfc_pkg::WIDTH_X36);
    pkt_en = packet_mode_i && wide_both;
    in_last = last_of(iw);
    out_last = last_of(ow);
    depth = CW'(32'(blocks_per_queue_i) * 32'(mqfc_pkg::BLOCK_WORDS));
  end

  // Per-queue flags; a queue whose blocks overrun the pool is unusable
  genvar g;
  generate
    for (g = 0; g < QN; g++) begin : g_queue
      assign q_ok[g] = (g < 32'(nq)) &&
        (32'(g + 1) * 32'(blocks_per_queue_i) <= 32'(POOL_BLOCKS));
      assign af_vec[g] = q_ok[g] &&
        ((af_off_reg[g] >= depth) || (cnt_reg[g] >= CW'(depth - af_off_reg[g])));
      assign ae_vec[g] = q_ok[g] && (cnt_reg[g] <= ae_off_reg[g]);
      assign pr_vec[g] = q_ok[g] && (pkt_reg[g] != '0);
    end
  endgenerate

  // Write side: pack narrow parts little endian, then queue through ingress FIFO
  assign wq = write_queue_address_i;
  assign accept = write_enable_i && !full_reg && push_s.ready;
  assign word_done = accept && (ipart_reg == in_last);
  assign push_s.valid = word_done;
  assign push_s.data = {wq, placed};

  always_comb begin
    case (iw)
      mqfc_pkg::WIDTH_X18: placed = pack_reg | (DW'(din_i[17:0]) << (18 * ipart_reg));
      mqfc_pkg::WIDTH_X9: placed = pack_reg | (DW'(din_i[8:0]) << (9 * ipart_reg));
      default: placed = din_i;
    endcase
    pack_next = pack_reg;
    ipart_next = ipart_reg;
    if (accept) begin
      pack_next = word_done ? '0 : placed;
      ipart_next = word_done ? 2'h0 : 2'(ipart_reg + 1'b1);
    end
  end

  // Drain stalls while the target queue is full, so the FIFO can fill
  assign dq = pop_s.data[EW-1:DW];
  assign dword = pop_s.data[DW-1:0];
  assign pop_s.ready = q_ok[dq] && (cnt_reg[dq] < depth);
  assign drain = pop_s.valid && pop_s.ready;

  // Read side: fall-through into the output register
  assign rq = read_queue_address_i;
  assign rword = pool_mem[base_of(rq, blocks_per_queue_i) + AW'(rptr_reg[rq])];
  assign consume = read_enable_i && ov_reg && (opart_reg == out_last);
  assign load = q_ok[rq] && (cnt_reg[rq] != '0) && (!ov_reg || consume);

  always_comb begin
    dout_next = dout_reg;
    ov_next = ov_reg;
    opart_next = opart_reg;
    if (load) begin
      dout_next = rword;
      ov_next = 1'b1;
      opart_next = 2'h0;
    end else if (consume) begin
      ov_next = 1'b0;
      opart_next = 2'h0;
    end else if (read_enable_i && ov_reg) begin
      dout_next = (ow == mqfc_pkg::WIDTH_X18) ? (dout_reg >> 18) : (dout_reg >> 9);
      opart_next = 2'(opart_reg + 1'b1);
    end
  end

  // Queue pointers, counts and packet tracking
  always_comb begin
    for (int q = 0; q < QN; q++) begin
      cnt_next[q] = cnt_reg[q];
      wptr_next[q] = wptr_reg[q];
      rptr_next[q] = rptr_reg[q];
      pkt_next[q] = pkt_reg[q];
    end
    inpkt_next = inpkt_reg;
    if (drain) begin
      wptr_next[dq] = (CW'(wptr_reg[dq] + 1'b1) == depth) ? '0 : CW'(wptr_reg[dq] + 1'b1);
      cnt_next[dq] = CW'(cnt_reg[dq] + 1'b1);
      if (pkt_en && dword[mqfc_pkg::SOP_BIT]) begin
        inpkt_next[dq] = 1'b1;
      end
      if (pkt_en && dword[mqfc_pkg::EOP_BIT] &&
          (inpkt_reg[dq] || dword[mqfc_pkg::SOP_BIT])) begin
        pkt_next[dq] = CW'(pkt_reg[dq] + 1'b1);
        inpkt_next[dq] = 1'b0;
      end
    end
    if (load) begin
      rptr_next[rq] = (CW'(rptr_reg[rq] + 1'b1) == depth) ? '0 : CW'(rptr_reg[rq] + 1'b1);
      cnt_next[rq] = CW'(cnt_next[rq] - 1'b1);
      if (pkt_en && rword[mqfc_pkg::EOP_BIT] && (pkt_next[rq] != '0)) begin
        pkt_next[rq] = CW'(pkt_next[rq] - 1'b1);
      end
    end
  end

  // Offsets: strap value during init window, then per-queue loads
  always_comb begin
    init_cnt_next = (init_cnt_reg == mqfc_pkg::INIT_WAIT) ? init_cnt_reg :
                    2'(init_cnt_reg + 1'b1);
    for (int q = 0; q < QN; q++) begin
      if (init_cnt_reg != mqfc_pkg::INIT_WAIT) begin
        af_off_next[q] = strap_sync_reg ? CW'(mqfc_pkg::OFFSET_HIGH) :
                         CW'(mqfc_pkg::OFFSET_LOW);
        ae_off_next[q] = af_off_next[q];
      end else if (offset_load_i && (offset_queue_i == QA'(q))) begin
        af_off_next[q] = offset_almost_full_i;
        ae_off_next[q] = offset_almost_empty_i;
      end else begin
        af_off_next[q] = af_off_reg[q];
        ae_off_next[q] = ae_off_reg[q];
      end
    end
  end

  // Dedicated flags and the two sector status buses
  always_comb begin
    // In-flight ingress words count too; the flag is for the previous cycle's wq, so a queue just switched to can still be over-committed
    full_next = !q_ok[wq] ||
                (32'(cnt_reg[wq]) + 32'(fifo_level) + 32'(word_done) >= 32'(depth)) ||
                (32'(fifo_level) >= FIFO_DEPTH - mqfc_pkg::FIFO_MARGIN);
    af_next = af_vec[wq];
    ae_next = !q_ok[rq] || ae_vec[rq];
    pr_next = pkt_en && pr_vec[rq];
    if (polled_mode_i) begin
      af_sec_next = (af_sec_reg == mqfc_pkg::SECTOR_ONE) ? mqfc_pkg::SECTOR_TWO :
                    mqfc_pkg::SECTOR_ONE;
      ae_sec_next = (ae_sec_reg == mqfc_pkg::SECTOR_ONE) ? mqfc_pkg::SECTOR_TWO :
                    mqfc_pkg::SECTOR_ONE;
    end else begin
      af_sec_next = full_bus_sector_strobe_i ?
        mqfc_pkg::mqfc_sector_t'(read_queue_address_i[mqfc_pkg::SECTOR_BIT]) :
        af_sec_reg;
      ae_sec_next = empty_bus_sector_strobe_i ?
        mqfc_pkg::mqfc_sector_t'(read_queue_address_i[mqfc_pkg::SECTOR_BIT]) :
        ae_sec_reg;
    end
    // Bits of unconfigured queues read low
    af_bus_next = (af_sec_next == mqfc_pkg::SECTOR_TWO) ? af_vec[QN-1:SW] :
                  af_vec[SW-1:0];
    ae_bus_next = pkt_en ?
      ((ae_sec_next == mqfc_pkg::SECTOR_TWO) ? pr_vec[QN-1:SW] : pr_vec[SW-1:0]) :
      ((ae_sec_next == mqfc_pkg::SECTOR_TWO) ? ae_vec[QN-1:SW] : ae_vec[SW-1:0]);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      init_cnt_reg <= 2'h0;
      pack_reg <= '0;
      ipart_reg <= 2'h0;
      opart_reg <= 2'h0;
      dout_reg <= '0;
      ov_reg <= 1'b0;
      full_reg <= 1'b1;
      af_reg <= 1'b0;
      ae_reg <= 1'b1;
      pr_reg <= 1'b0;
      af_sec_reg <= mqfc_pkg::SECTOR_ONE;
      ae_sec_reg <= mqfc_pkg::SECTOR_ONE;
      af_bus_reg <= '0;
      ae_bus_reg <= '0;
      inpkt_reg <= '0;
      for (int q = 0; q < QN; q++) begin
        cnt_reg[q] <= '0;
        wptr_reg[q] <= '0;
        rptr_reg[q] <= '0;
        pkt_reg[q] <= '0;
        af_off_reg[q] <= '0;
        ae_off_reg[q] <= '0;
      end
    end else begin
      strap_meta_reg <= default_offset_select_i;
      strap_sync_reg <= strap_meta_reg;
      init_cnt_reg <= init_cnt_next;
      pack_reg <= pack_next;
      ipart_reg <= ipart_next;
      opart_reg <= opart_next;
      dout_reg <= dout_next;
      ov_reg <= ov_next;
      full_reg <= full_next;
      af_reg <= af_next;
      ae_reg <= ae_next;
      pr_reg <= pr_next;
      af_sec_reg <= af_sec_next;
      ae_sec_reg <= ae_sec_next;
      af_bus_reg <= af_bus_next;
      ae_bus_reg <= ae_bus_next;
      inpkt_reg <= inpkt_next;
      for (int q = 0; q < QN; q++) begin
        cnt_reg[q] <= cnt_next[q];
        wptr_reg[q] <= wptr_next[q];
        rptr_reg[q] <= rptr_next[q];
        pkt_reg[q] <= pkt_next[q];
        af_off_reg[q] <= af_off_next[q];
        ae_off_reg[q] <= ae_off_next[q];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (drain) begin
      pool_mem[base_of(dq, blocks_per_queue_i) + AW'(wptr_reg[dq])] <= dword;
    end
  end

  assign dout_o = dout_reg;
  assign output_valid_flag_o = ov_reg;
  assign queue_full_flag_o = full_reg;
  assign almost_full_flag_o = af_reg;
  assign almost_empty_flag_o = ae_reg;
  assign packet_ready_flag_o = pr_reg;
  assign almost_full_status_bus_o = af_bus_reg;
  assign almost_empty_status_bus_o = ae_bus_reg;
  assign full_bus_sector_o = (af_sec_reg == mqfc_pkg::SECTOR_TWO);
  assign empty_bus_sector_o = (ae_sec_reg == mqfc_pkg::SECTOR_TWO);

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_polled_two;
    polled_mode_i [*2];
  endsequence

  a_fall_through: assert property ((!ov_reg && q_ok[rq] && cnt_reg[rq] != '0)
    |=> ov_reg) else $error("Waiting word did not fall through");
  a_no_empty_read: assert property ((!ov_reg && cnt_reg[rq] == '0)
    |=> !output_valid_flag_o) else $error("Valid raised with empty queue");
  a_hold_last_word: assert property ((cnt_reg[rq] == '0 && !(read_enable_i && ov_reg))
    |=> $stable(dout_reg)) else $error("Output word changed with empty queue");
  a_queue_bounded: assert property (cnt_reg[dq] <= depth)
    else $error("Queue count above its depth");
  a_full_at_depth: assert property ((cnt_reg[wq] >= depth) |=> queue_full_flag_o)
    else $error("Full flag low with queue at depth");
  a_polled_steps: assert property (s_polled_two |->
    af_sec_reg != $past(af_sec_reg)) else $error("Full bus sector did not step");
  a_modes_shared: assert property (s_polled_two |->
    ae_sec_reg != $past(ae_sec_reg)) else $error("Empty bus sector did not step");
  a_direct_full_sel: assert property ((!polled_mode_i && full_bus_sector_strobe_i)
    |=> full_bus_sector_o == $past(read_queue_address_i[mqfc_pkg::SECTOR_BIT]))
    else $error("Full bus sector not taken from read address");
  a_direct_empty_sel: assert property ((!polled_mode_i && empty_bus_sector_strobe_i)
    |=> empty_bus_sector_o == $past(read_queue_address_i[mqfc_pkg::SECTOR_BIT]))
    else $error("Empty bus sector not taken from read address");
  a_packet_ready: assert property ((pkt_en && pr_vec[rq]) |=> packet_ready_flag_o)
    else $error("Packet ready missing with complete packet");
  a_packet_width: assert property (!wide_both |=> !packet_ready_flag_o)
    else $error("Packet ready with narrow port");
  a_default_offset: assert property ((init_cnt_reg != mqfc_pkg::INIT_WAIT)
    |=> af_off_reg[0] == ($past(strap_sync_reg) ? CW'(mqfc_pkg::OFFSET_HIGH) :
        CW'(mqfc_pkg::OFFSET_LOW))) else $error("Default offset not loaded");
endmodule

//--- mqfc_reader.sv
// Purpose: Downstream reader model for the multi-queue FIFO
// Assumes: Device ignores a read enable while its valid flag is low
// Notes: Stall lets the bench make the reader prompt or slow
`timescale 1ns/1ps
module mqfc_reader (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic stall_i,
  output logic read_enable_o
);
  // Registered so the enable only moves just after an edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      read_enable_o <= 1'b0;
    end else begin
      read_enable_o <= !stall_i;
    end
  end
endmodule

//--- tb_mqfc_core.sv
// Purpose: Self-checking bench for the multi-queue flow-control FIFO
// Assumes: Pool of 4 blocks, one block per queue, four queues, x36 ports except the x9 read and x18 write runs
// Notes: Small pool keeps fill runs short; expectations kept per queue
`timescale 1ns/1ps
module tb_mqfc_core;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic polled = 1'b1, pkt = 1'b0, dfl = 1'b0, we = 1'b0, stall = 1'b1;
  logic fstb = 1'b0, estb = 1'b0, re, ok, ff, af, ov, ae, pr, fsec, esec;
  logic [4:0] nq = 5'h04;
  logic [8:0] blk = 9'h001;
  logic [1:0] wid = mqfc_pkg::WIDTH_X36, owid = mqfc_pkg::WIDTH_X36;
  logic oload = 1'b0;
  logic [3:0] oq = 4'h0;
  logic [10:0] oaf = 11'h000, oae = 11'h000;
  logic [3:0] wq = 4'h0, rq = 4'h0;
  logic [35:0] din = 36'h0, dout, last, seen;
  logic [7:0] afb, aeb;
  logic [35:0] exp_q[4][$];
  int bad_count = 0, cmp_count = 0, cyc = 0, acc;

  always #25 clk = ~clk;

  mqfc_core #(.POOL_BLOCKS(4)) DUT (.clk_i(clk), .reset_n_i(reset_n),
    .num_queues_i(nq), .blocks_per_queue_i(blk), .in_width_i(wid), .out_width_i(owid),
    .packet_mode_i(pkt), .polled_mode_i(polled), .default_offset_select_i(dfl),
    .offset_load_i(oload), .offset_queue_i(oq), .offset_almost_full_i(oaf),
    .offset_almost_empty_i(oae), .write_enable_i(we), .write_queue_address_i(wq),
    .din_i(din), .read_enable_i(re), .read_queue_address_i(rq),
    .full_bus_sector_strobe_i(fstb), .empty_bus_sector_strobe_i(estb), .dout_o(dout),
    .queue_full_flag_o(ff), .almost_full_flag_o(af), .output_valid_flag_o(ov),
    .almost_empty_flag_o(ae), .packet_ready_flag_o(pr), .almost_full_status_bus_o(afb),
    .almost_empty_status_bus_o(aeb), .full_bus_sector_o(fsec), .empty_bus_sector_o(esec));

  mqfc_reader PART (.clk_i(clk), .reset_n_i(reset_n), .stall_i(stall), .read_enable_o(re));

  task chk(input string n, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [35:0] rnd();
    return {2'h0, 2'($urandom), 32'($urandom)};
  endfunction

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Flag is registered, so its value now is what the next edge samples
  task wr(input logic [3:0] q, input logic [35:0] d);
    wq = q;
    din = d;
    we = 1'b1;
    ok = !ff;
    step(1);
    if (ok && owid == mqfc_pkg::WIDTH_X9) begin
      for (int i = 0; i < 4; i++) exp_q[q].push_back(36'(d[9*i +: 9]));
    end else if (ok) begin
      exp_q[q].push_back(d);
    end
  endtask

  // Two x18 parts, low half first; only used on a nearly empty queue
  task wr18(input logic [3:0] q, input logic [35:0] d);
    wq = q;
    we = 1'b1;
    din = 36'(d[17:0]);
    step(1);
    din = 36'(d[35:18]);
    step(1);
    exp_q[q].push_back(d);
  endtask

  task idle(input int n);
    we = 1'b0;
    step(n);
  endtask

  task rst(input logic p, input logic k);
    reset_n = 1'b0;
    polled = p;
    pkt = k;
    for (int i = 0; i < 4; i++) exp_q[i].delete();
    step(8);
    chk("full", 36'h1, 36'(ff));
    chk("valid", 36'h0, 36'(ov));
    reset_n = 1'b1;
  endtask

  task drain(input logic [3:0] q);
    rq = q;
    for (int i = 0; i < 2000; i++) begin
      step(1);
      if (exp_q[q].size() == 0 && ov === 1'b0) break;
      stall = ($urandom % 3 == 0);
    end
    stall = 1'b1;
    chk("left", 36'h0, 36'(exp_q[q].size()));
  endtask

  // Word taken at this edge is the one shown before the edge
  always @(posedge clk) begin
    if (reset_n && re && ov === 1'b1) begin
      seen = (owid == mqfc_pkg::WIDTH_X9) ? 36'(dout[8:0]) : dout;
      chk("dout", exp_q[rq].size() ? exp_q[rq].pop_front() : 'x, seen);
    end
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      stop_test;
    end
  end

  initial begin
    void'($urandom(32'h9657));
    rst(1'b1, 1'b0);
    for (int i = 1; i <= 4; i++) begin
      step(1);
      chk("fsec", 36'(i % 2), 36'(fsec));
      chk("esec", 36'(i % 2), 36'(esec));
    end
    for (int i = 0; i < 40; i++) wr(4'($urandom % 4), rnd());
    idle(4);
    for (int q = 0; q < 4; q++) drain(4'(q));
    last = dout;
    rq = 4'h0;
    step(3);
    chk("hold", last, dout);
    chk("valid", 36'h0, 36'(ov));
    acc = 0;
    repeat (247) begin
      wr(4'h2, rnd());
      acc += int'(ok);
    end
    idle(6);
    chk("af", 36'h0, 36'(af));
    wr(4'h2, rnd());
    acc += int'(ok);
    idle(6);
    chk("af", 36'h1, 36'(af));
    repeat (20) begin
      wr(4'h2, rnd());
      acc += int'(ok);
    end
    idle(6);
    chk("accepted", 36'h100, 36'(acc));
    chk("full", 36'h1, 36'(ff));
    rq = 4'h2;
    step(3);
    chk("ae", 36'h0, 36'(ae));
    for (int i = 0; i < 3; i++) wr(4'h1, rnd());
    idle(6);
    rq = 4'h1;
    step(3);
    chk("ae", 36'h1, 36'(ae));
    // Own thresholds for queue 1: almost full from 3 words, almost empty at 2 or less
    oq = 4'h1;
    oaf = 11'h0FD;
    oae = 11'h002;
    oload = 1'b1;
    step(1);
    oload = 1'b0;
    step(2);
    chk("ae", 36'h0, 36'(ae));
    chk("af", 36'h1, 36'(af));
    if (fsec === 1'b1) step(1);
    chk("afbus", 36'h06, 36'(afb));
    chk("aebus", 36'h09, 36'(aeb));
    step(1);
    chk("afbus", 36'h00, 36'(afb));
    drain(4'h2);
    drain(4'h1);
    rst(1'b0, 1'b1);
    step(4);
    rq = 4'h8;
    fstb = 1'b1;
    step(1);
    chk("fsec", 36'h1, 36'(fsec));
    chk("esec", 36'h0, 36'(esec));
    fstb = 1'b0;
    estb = 1'b1;
    step(1);
    chk("esec", 36'h1, 36'(esec));
    rq = 4'h0;
    step(1);
    estb = 1'b0;
    chk("esec", 36'h0, 36'(esec));
    chk("fsec", 36'h1, 36'(fsec));
    wr(4'h0, {2'h1, 34'h1});
    wr(4'h0, rnd());
    idle(6);
    chk("pr", 36'h0, 36'(pr));
    wr(4'h0, {2'h2, 34'h3});
    idle(6);
    chk("pr", 36'h1, 36'(pr));
    chk("aebus", 36'h01, 36'(aeb));
    drain(4'h0);
    chk("pr", 36'h0, 36'(pr));
    // Narrow read port, four x9 parts per word; high strap gives offset 128
    owid = mqfc_pkg::WIDTH_X9;
    dfl = 1'b1;
    rst(1'b1, 1'b0);
    step(4);
    for (int i = 0; i < 20; i++) wr(4'h3, rnd());
    idle(6);
    rq = 4'h3;
    step(3);
    chk("ae", 36'h1, 36'(ae));
    drain(4'h3);
    // Narrow write port: packet markers must not count
    wid = mqfc_pkg::WIDTH_X18;
    owid = mqfc_pkg::WIDTH_X36;
    rst(1'b1, 1'b1);
    step(4);
    wr18(4'h0, {2'h3, 34'h1_2345_6789});
    idle(6);
    chk("pr", 36'h0, 36'(pr));
    if (esec === 1'b1) step(1);
    chk("aebus", 36'h0F, 36'(aeb));
    drain(4'h0);
    stop_test;
  end
endmodule
